/* design/eeprom_defines.svh */
`ifndef EEPROM_DEFINES_SVH
`define EEPROM_DEFINES_SVH
// System clock rate
`define EE_CLK_MHZ 100
// Spike filter: input must hold this long before it is believed
`define EE_FILT_NS 50
`define EE_FILT_CYC ((`EE_FILT_NS * `EE_CLK_MHZ + 999) / 1000)
// Self-timed programming time after the drain
`define EE_WR_US 5000
`define EE_WR_CYC (`EE_WR_US * `EE_CLK_MHZ)
// Page buffer depth and data width
`define EE_PAGE_DEPTH 8
`define EE_DATA_W 8
// Bit counter marks inside one nine-clock byte slot
`define EE_ACK_BIT 4'h8
`define EE_END_BIT 4'h9
`endif

/* design/eeprom_pkg.sv */
package eeprom_pkg;
  // Protocol states, Gray coded along idle-address-word-data
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DEVADDR = 3'h1,
    ST_WORD = 3'h3,
    ST_WRDATA = 3'h2,
    ST_RDDATA = 3'h6
  } proto_e;
  typedef logic [7:0] byte_t;
endpackage : eeprom_pkg

/* design/serial_eeprom.sv */
// Functional notes
// - Never program while write protect is high.
// - Protected write: ack addresses, nack first data.
// - Protected write stop starts no programming.
// - Current read returns last location plus one.
// - Read address acked, byte sent MSB first.
// - Master nack then stop: release the line.
// - Word address loads pointer despite abandoned write.
// - Read after repeated start returns loaded address.
// - Master ack gets the next sequential byte.
// - Pointer increments after every byte read and every acked byte written.
// - Filter spikes on clock and data inputs.
// - Address byte: type code, chip selects, direction.
// - No address ack while programming runs.
`timescale 1ns/1ps
`include "eeprom_defines.svh"

// Two-flop synchroniser followed by a hold-time spike filter
module pin_filter #(parameter int N = 5) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pin_i,
  output logic flt_o
);
  logic s1_q, s2_q, out_q, out_d; // Sync stages and filtered level
  logic [7:0] cnt_q, cnt_d; // Cycles the new level has held
  // Only a level that holds N cycles passes; shorter spikes die here
  always_comb begin
    out_d = out_q;
    cnt_d = 8'h00;
    if (s2_q != out_q) begin
      cnt_d = cnt_q + 8'h01;
      if (cnt_q == 8'(N - 1)) begin
        out_d = s2_q;
        cnt_d = 8'h00;
      end
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      out_q <= 1'b1;
      cnt_q <= 8'h00;
    end else begin
      s1_q <= pin_i;
      s2_q <= s1_q;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end
  assign flt_o = out_q;
  AST_FILT_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(out_q) |-> $past(cnt_q) == 8'(N - 1) && out_q == $past(s2_q))
    else $error("filter output changed before the hold time");
endmodule : pin_filter

// Page buffer; drained only while programming, so it really fills
module page_fifo #(parameter int W = 8, parameter int D = 8) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clr_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D]; // Storage
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d; // Write and read pointers
  logic [AW:0] cnt_q, cnt_d; // Fill level
  logic push, pop;
  assign in_ready_o = (cnt_q != (AW+1)'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rp_q];
  // Pointer and level update
  always_comb begin
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    wp_d = push ? wp_q + AW'(1) : wp_q;
    rp_d = pop ? rp_q + AW'(1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    if (clr_i) begin
      wp_d = '0;
      rp_d = '0;
      cnt_d = '0;
    end
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end
  // Storage has no reset; contents are dead until pushed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp_q] <= in_data_i;
    end
  end
endmodule : page_fifo

module serial_eeprom #(
  parameter logic [3:0] DEV_CODE = 4'h5, // Device type code, arbitrary value
  parameter int WR_CYC = `EE_WR_CYC // Programming time in cycles
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic SYS_RST_I,
  // Two-wire bus
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_N_O,
  // Straps
  input wire logic [2:0] CHIP_SELECT_I,
  input wire logic WR_PROTECT_I
);
  import eeprom_pkg::*;
  logic scl_f, sda_f, scl_p, sda_p; // Filtered levels and last values
  logic [3:0] pin_s1, pin_s2; // Strap synchroniser
  logic wp_s; // Synced write protect
  logic start, stop, scl_rise, scl_fall;
  proto_e st_q, st_d; // Protocol state
  logic [3:0] cnt_q, cnt_d; // Clock count within a byte slot
  byte_t rx_q, rx_d, tx_q, tx_d; // Shift registers
  byte_t ptr_q, ptr_d, base_q, base_d; // Address pointer and page base
  logic drv_q, drv_d; // Pulling the data line low
  logic rw_q, rw_d, prot_q, prot_d, wr_q, wr_d, prog_q, prog_d;
  logic [2:0] off_q, off_d; // Offset inside page while draining
  logic [18:0] tmr_q, tmr_d; // Programming timer
  logic push, flush, ld, mem_we, busy, fifo_rdy, pop_v;
  byte_t pop_data, mem_rd;
  byte_t mem [256]; // The array itself

  pin_filter #(.N(`EE_FILT_CYC)) u_scl (.clk_i(CLK_I), .rst_i(SYS_RST_I), .pin_i(SCL_I), .flt_o(scl_f));
  pin_filter #(.N(`EE_FILT_CYC)) u_sda (.clk_i(CLK_I), .rst_i(SYS_RST_I), .pin_i(SDA_I), .flt_o(sda_f));
  page_fifo #(.W(`EE_DATA_W), .D(`EE_PAGE_DEPTH)) u_page (.clk_i(CLK_I), .rst_i(SYS_RST_I), .clr_i(flush),
    .in_valid_i(push), .in_ready_o(fifo_rdy), .in_data_i(rx_q), .out_valid_o(pop_v),
    .out_ready_i(prog_q), .out_data_o(pop_data));

  assign wp_s = pin_s2[3];
  assign scl_rise = scl_f && !scl_p;
  assign scl_fall = !scl_f && scl_p;
  // Data edges while the clock stays high are bus conditions
  assign start = scl_f && scl_p && sda_p && !sda_f;
  assign stop = scl_f && scl_p && !sda_p && sda_f;
  assign busy = prog_q || (tmr_q != 19'h00000);
  assign mem_rd = mem[ptr_q];
  // Open drain: only ever drive low
  assign SDA_O = 1'b0;
  assign SDA_OE_N_O = !drv_q;

  // Protocol, pointer and programming next state
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    base_d = base_q;
    drv_d = drv_q;
    rw_d = rw_q;
    prot_d = prot_q;
    wr_d = wr_q;
    prog_d = prog_q;
    off_d = off_q;
    tmr_d = tmr_q;
    push = 1'b0;
    flush = 1'b0;
    ld = 1'b0;
    mem_we = 1'b0;
    // Drain the page into the array, then run the self-timed wait
    if (prog_q) begin
      if (pop_v) begin
        mem_we = 1'b1;
        off_d = off_q + 3'h1;
      end else begin
        prog_d = 1'b0;
        tmr_d = 19'(WR_CYC);
      end
    end else if (tmr_q != 19'h00000) begin
      tmr_d = tmr_q - 19'h00001;
    end
    if (start) begin
      // Repeated start abandons a write; pointer keeps its load
      st_d = ST_DEVADDR;
      cnt_d = 4'h0;
      drv_d = 1'b0;
      prot_d = 1'b0;
      wr_d = 1'b0;
      flush = !prog_q;
    end else if (stop) begin
      st_d = ST_IDLE;
      drv_d = 1'b0;
      if (wr_q && !prot_q && !wp_s) begin
        prog_d = 1'b1;
        off_d = 3'h0;
      end else if (!prog_q) begin
        flush = 1'b1;
      end
    end else if (st_q != ST_IDLE && scl_rise) begin
      cnt_d = cnt_q + 4'h1;
      rx_d = {rx_q[6:0], sda_f};
      // Master left its ack high: stop sending
      if (st_q == ST_RDDATA && cnt_q == `EE_ACK_BIT && sda_f) begin
        st_d = ST_IDLE;
      end
    end else if (st_q != ST_IDLE && scl_fall) begin
      if (cnt_q == `EE_ACK_BIT && st_q != ST_RDDATA) begin
        case (st_q)
          ST_DEVADDR: begin
            // Type code, chip selects, then direction bit
            if (rx_q[7:4] == DEV_CODE && rx_q[3:1] == pin_s2[2:0] && !busy) begin
              drv_d = 1'b1;
              rw_d = rx_q[0];
            end else begin
              st_d = ST_IDLE;
            end
          end
          ST_WORD: begin
            drv_d = 1'b1;
            ptr_d = rx_q;
            base_d = rx_q;
          end
          default: begin
            // Data byte: protected or page full gets no ack
            if (!wp_s && fifo_rdy) begin
              drv_d = 1'b1;
              push = 1'b1;
              ptr_d = ptr_q + 8'h01;
              wr_d = 1'b1;
            end else begin
              prot_d = wp_s;
              st_d = ST_IDLE;
            end
          end
        endcase
      end else if (cnt_q == `EE_ACK_BIT) begin
        drv_d = 1'b0; // Hand the line to the master for its ack
      end else if (cnt_q == `EE_END_BIT) begin
        cnt_d = 4'h0;
        drv_d = 1'b0;
        case (st_q)
          ST_DEVADDR: begin
            if (rw_q) begin
              st_d = ST_RDDATA;
              ld = 1'b1;
            end else begin
              st_d = ST_WORD;
            end
          end
          ST_WORD: st_d = ST_WRDATA;
          ST_RDDATA: ld = 1'b1;
          default: st_d = st_q;
        endcase
      end else if (st_q == ST_RDDATA) begin
        drv_d = !tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
      end
      // Load the byte at the pointer, present its MSB, advance
      if (ld) begin
        drv_d = !mem_rd[7];
        tx_d = {mem_rd[6:0], 1'b0};
        ptr_d = ptr_q + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      base_q <= 8'h00;
      drv_q <= 1'b0;
      rw_q <= 1'b0;
      prot_q <= 1'b0;
      wr_q <= 1'b0;
      prog_q <= 1'b0;
      off_q <= 3'h0;
      tmr_q <= 19'h00000;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      base_q <= base_d;
      drv_q <= drv_d;
      rw_q <= rw_d;
      prot_q <= prot_d;
      wr_q <= wr_d;
      prog_q <= prog_d;
      off_q <= off_d;
      tmr_q <= tmr_d;
      scl_p <= scl_f;
      sda_p <= sda_f;
      pin_s1 <= {WR_PROTECT_I, CHIP_SELECT_I};
      pin_s2 <= pin_s1;
    end
  end

  // Array write; page offset wraps inside the page
  always_ff @(posedge CLK_I) begin
    if (mem_we) begin
      mem[{base_q[7:3], base_q[2:0] + off_q}] <= pop_data;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);
  sequence seq_master_nack;
    st_q == ST_RDDATA && scl_rise && cnt_q == `EE_ACK_BIT && sda_f;
  endsequence
  sequence seq_wp_data_slot;
    st_q == ST_WRDATA && scl_fall && cnt_q == `EE_ACK_BIT && wp_s && !start && !stop;
  endsequence
  AST_WP_NO_PROG: assert property (stop && wp_s && !prog_q |=> !prog_q)
    else $error("programming started under write protect");
  AST_WP_NACK: assert property (seq_wp_data_slot |=> !drv_q && st_q == ST_IDLE && prot_q)
    else $error("protected data byte was acked");
  AST_PROT_STOP: assert property (stop && prot_q && !prog_q |=> !prog_q)
    else $error("protected write started programming");
  AST_PTR_INC: assert property (ld |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("pointer did not advance after a read load");
  AST_MSB_FIRST: assert property (ld |=> drv_q == !$past(mem_rd[7]) && tx_q[7] == $past(mem_rd[6]))
    else $error("read byte not started with its MSB");
  AST_NACK_RELEASE: assert property (seq_master_nack |=> st_q == ST_IDLE ##1 !drv_q [*3])
    else $error("line still driven after master nack");
  AST_WORD_LOAD: assert property (st_q == ST_WORD && scl_fall && cnt_q == `EE_ACK_BIT && !start && !stop
    |=> ptr_q == $past(rx_q) && drv_q)
    else $error("word address not loaded into pointer");
  AST_BUSY_NOACK: assert property (st_q == ST_DEVADDR && scl_fall && cnt_q == `EE_ACK_BIT && busy
    && !start && !stop |=> !drv_q)
    else $error("address acked while programming");
  AST_PTR_WRAP: assert property (ld && ptr_q == 8'hFF |=> ptr_q == 8'h00)
    else $error("pointer did not wrap to zero");
endmodule : serial_eeprom

/* bench/bus_master.sv */
`timescale 1ns/1ps
// Two-wire master; every change lands on a falling system clock edge
module bus_master (
  // System side
  input wire logic clk_i,
  // Bus side
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  import eeprom_pkg::*;
  // SCL high time; the low phase of a bit is twice this. Far above the device's spike filter
  localparam int HALF = 25;
  // Bus idle high, sda_o low means pulling the wire down
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // Wait n system cycles
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : idle
  // Start or repeated start, leaves SCL low
  task automatic start();
    sda_o = 1'b1;
    idle(HALF);
    scl_o = 1'b1;
    idle(HALF);
    sda_o = 1'b0;
    idle(HALF);
    scl_o = 1'b0;
    idle(HALF);
  endtask : start
  // Stop, leaves the bus idle
  task automatic stop();
    sda_o = 1'b0;
    idle(HALF);
    scl_o = 1'b1;
    idle(HALF);
    sda_o = 1'b1;
    idle(HALF);
  endtask : stop
  // One clock pulse, wire sampled late in the high phase
  task automatic pulse(output logic seen);
    scl_o = 1'b1;
    idle(HALF);
    seen = sda_i;
    scl_o = 1'b0;
    idle(HALF);
  endtask : pulse
  // Send a byte MSB first; g adds a short SCL spike that must be ignored
  task automatic wr_byte(input byte_t b, input logic g, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      idle(HALF);
      if (g && i == 3) begin
        scl_o = 1'b1;
        idle(2);
        scl_o = 1'b0;
        idle(HALF);
      end
      pulse(s);
    end
    sda_o = 1'b1;
    idle(HALF);
    pulse(s);
    ack = !s;
  endtask : wr_byte
  // Receive a byte, then ack (more wanted) or leave the line high
  task automatic rd_byte(input logic mack, output byte_t d);
    logic s;
    sda_o = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      idle(HALF);
      pulse(s);
      d[i] = s;
    end
    sda_o = !mack;
    idle(HALF);
    pulse(s);
    sda_o = 1'b1;
  endtask : rd_byte
endmodule : bus_master

/* bench/test_serial_eeprom.sv */
`timescale 1ns/1ps
module test_serial_eeprom;
  import eeprom_pkg::*;
  localparam logic [3:0] DEV = 4'h5; // Type code, arbitrary value
  localparam logic [2:0] CS = 3'h5; // Strap setting
  logic clk = 1'b0; // System clock
  logic rst = 1'b1; // Reset, active high
  logic wp = 1'b0; // Write protect strap
  logic scl; // Bus clock from the master
  logic sda_m; // Master side, low pulls
  logic sda_o; // Device data value
  logic oe_n; // Device enable, low drives
  wire sda = sda_m & (oe_n | sda_o); // Open drain with pull-up
  int miscompares = 0;
  int samples_checked = 0;
  always #5 clk = ~clk;
  // Short programming time keeps the run small
  serial_eeprom #(.DEV_CODE(DEV), .WR_CYC(2000)) i_dut (.CLK_I(clk), .SYS_RST_I(rst), .SCL_I(scl),
    .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_N_O(oe_n), .CHIP_SELECT_I(CS), .WR_PROTECT_I(wp));
  bus_master i_master (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done
  // Start plus address byte
  task automatic addr(input logic rd, input logic [2:0] cs, output logic ack);
    i_master.start();
    i_master.wr_byte({DEV, cs, rd}, 1'b0, ack);
  endtask : addr
  // Write address then word address, both acked
  task automatic set_ptr(input byte_t w, input logic g);
    logic a;
    addr(1'b0, CS, a);
    check({7'h0, a}, 8'h01);
    i_master.wr_byte(w, g, a);
    check({7'h0, a}, 8'h01);
  endtask : set_ptr
  // Busy right after the stop, then poll until acked
  task automatic wait_ready();
    logic a;
    addr(1'b0, CS, a);
    i_master.stop();
    check({7'h0, a}, 8'h00);
    for (int k = 0; k < 20; k++) begin
      addr(1'b0, CS, a);
      i_master.stop();
      if (a === 1'b1) return;
    end
    miscompares++;
    $display("MISMATCH %0t: device stays busy", $time);
    test_done();
  endtask : wait_ready
  // Single byte write and wait for programming
  task automatic wr1(input byte_t w, input byte_t d);
    logic a;
    set_ptr(w, 1'b0);
    i_master.wr_byte(d, 1'b0, a);
    check({7'h0, a}, 8'h01);
    i_master.stop();
    wait_ready();
  endtask : wr1
  // Random read: pointer load, repeated start, read address
  task automatic rd_at(input byte_t w, input logic g);
    logic a;
    set_ptr(w, g);
    addr(1'b1, CS, a);
    check({7'h0, a}, 8'h01);
  endtask : rd_at
  // Read one byte and compare
  task automatic rd(input logic mack, input byte_t exp);
    byte_t d;
    i_master.rd_byte(mack, d);
    check(d, exp);
  endtask : rd
  // Nine data bytes; the full buffer refuses the ninth
  task automatic t_page();
    logic a;
    set_ptr(8'h10, 1'b0);
    for (int i = 0; i < 9; i++) begin
      i_master.wr_byte(8'hA0 + 8'(i), 1'b0, a);
      check({7'h0, a}, {7'h0, i < 8});
    end
    i_master.stop();
    wait_ready();
    $display("page write done");
  endtask : t_page
  // Sequential read through a spiked word address, then current read
  task automatic t_read();
    logic a;
    rd_at(8'h10, 1'b1);
    rd(1'b1, 8'hA0);
    rd(1'b1, 8'hA1);
    rd(1'b0, 8'hA2);
    i_master.stop();
    check({7'h0, oe_n}, 8'h01);
    addr(1'b1, CS, a);
    rd(1'b0, 8'hA3);
    i_master.stop();
    $display("read done");
  endtask : t_read
  // Protected write: data refused, no busy period, memory unchanged
  task automatic t_protect();
    logic a;
    wp = 1'b1;
    set_ptr(8'h10, 1'b0);
    i_master.wr_byte(8'h55, 1'b0, a);
    check({7'h0, a}, 8'h00);
    i_master.stop();
    addr(1'b0, CS, a);
    i_master.stop();
    check({7'h0, a}, 8'h01);
    wp = 1'b0;
    rd_at(8'h10, 1'b0);
    rd(1'b0, 8'hA0);
    i_master.stop();
    $display("protect done");
  endtask : t_protect
  // Pointer wraps from the top location to zero; wrong strap ignored
  task automatic t_wrap();
    logic a;
    wr1(8'h00, 8'h33);
    wr1(8'hFF, 8'h5A);
    rd_at(8'hFF, 1'b0);
    rd(1'b1, 8'h5A);
    rd(1'b0, 8'h33);
    i_master.stop();
    addr(1'b1, CS ^ 3'h1, a);
    i_master.stop();
    check({7'h0, a}, 8'h00);
    $display("wrap done");
  endtask : t_wrap
  // Mid-run reset: line released, pointer back to zero, array contents kept
  task automatic t_reset();
    logic a;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    check({7'h0, oe_n}, 8'h01);
    rst = 1'b0;
    // Filters restart at the idle level, so give them time before the first start
    repeat (20) @(negedge clk);
    addr(1'b1, CS, a);
    check({7'h0, a}, 8'h01);
    rd(1'b0, 8'h33);
    i_master.stop();
    $display("reset done");
  endtask : t_reset
  // Reset for three cycles, let the filters settle, run the tests
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (20) @(negedge clk);
    t_page();
    t_read();
    t_protect();
    t_wrap();
    t_reset();
    test_done();
  end
endmodule : test_serial_eeprom
